// ===== dpa_chk_sva.sv
// Concurrent checks on the port controller pins
`timescale 1ns/100ps
module dpa_chk #(parameter int P_ADDR_W = 15) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire logic [1:0] i_cmd,
    input wire logic i_retention,
    input wire logic i_collision_n,
    input wire logic o_ready,
    input wire logic o_done,
    input wire logic [P_ADDR_W-1:0] o_addr,
    input wire logic o_array_sel_n,
    input wire logic o_flag_select_n,
    input wire logic o_rw_n,
    input wire logic o_out_drive_n,
    input wire logic o_data_oe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // Pin-level timing relations
    chk_addr_hold: assert property (
        !$stable(o_addr) |-> o_rw_n && $past(o_rw_n))
        else $error("addr moved");
    chk_sel_excl: assert property (
        !(!o_array_sel_n && !o_flag_select_n)) else $error("both selects");
    chk_pulse_len: assert property (
        $fell(o_rw_n) |-> !o_rw_n [*4]) else $error("short write pulse");
    chk_write_sel: assert property (
        !o_rw_n |-> o_data_oe && (!o_array_sel_n || !o_flag_select_n))
        else $error("strobe without select");
    chk_read_style: assert property (
        !o_out_drive_n |-> o_rw_n && !o_data_oe) else $error("bad read");
    chk_flag_done: assert property (
        i_req && o_ready && !i_retention && i_cmd == 2'h2
        ##1 i_collision_n [*7] |=> o_done) else $error("flag read late");
    chk_flag_gap: assert property (
        $rose(o_flag_select_n) |-> (o_flag_select_n && o_array_sel_n) [*3])
        else $error("flag gap short");
    chk_retain_sel: assert property (
        i_retention ##1 i_retention |-> !$fell(o_array_sel_n))
        else $error("select in retention");
    chk_slave_hold: assert property (
        $rose(i_collision_n) && o_rw_n && !o_array_sel_n |-> o_rw_n [*4])
        else $error("strobe after collision");
endmodule
bind dpa_port_ctrl dpa_chk #(.P_ADDR_W(P_ADDR_W)) u_chk (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_req(i_req), .i_cmd(i_cmd),
    .i_retention(i_retention), .i_collision_n(i_collision_n),
    .o_ready(o_ready), .o_done(o_done), .o_addr(o_addr),
    .o_array_sel_n(o_array_sel_n), .o_flag_select_n(o_flag_select_n),
    .o_rw_n(o_rw_n), .o_out_drive_n(o_out_drive_n), .o_data_oe(o_data_oe));

// ===== dpa_dev_model.sv
// Behavioural model of one device port with its flags
`timescale 1ns/100ps
module dpa_dev_model (
    input wire logic i_clock,
    input wire logic [14:0] i_addr,
    input wire logic i_array_sel_n,
    input wire logic i_flag_select_n,
    input wire logic i_rw_n,
    input wire logic i_out_drive_n,
    input wire logic [8:0] i_host_data,
    input wire logic i_host_oe,
    input wire logic i_peer_req,
    input wire logic i_peer_rel,
    output logic [8:0] o_bus
);
    logic [8:0] mem [0:255];
    // Flags start free to both ports
    logic [1:0] own [0:7] = '{default: 2'h0};
    logic [7:0] our_wait = 8'h00;
    logic [8:0] last = 9'h000;
    logic wr_d = 1'b0;
    logic wr, rd, sel, commit;
    logic [2:0] f;
    logic [8:0] q, flag_q;
    // Access decode
    assign sel = !i_array_sel_n || !i_flag_select_n;
    assign wr = !i_rw_n && sel;
    assign rd = i_rw_n && !i_out_drive_n && sel;
    assign f = i_addr[2:0];
    assign commit = wr_d && !wr;
    // Flag reads one unless this port holds it
    assign flag_q = {9{own[f] != 2'h1}};
    assign q = !i_array_sel_n ? mem[i_addr[7:0]] : flag_q;
    // Released bus shows a changing pattern
    assign o_bus = rd ? q : (i_host_oe ? i_host_data : ~last);
    // Commit at end of write overlap; peer works on flag 1
    always @(posedge i_clock) begin
        last <= o_bus;
        wr_d <= wr;
        // Shared cells, so the other port sees the word at once
        if (commit && !i_array_sel_n) begin
            mem[i_addr[7:0]] <= i_host_data;
        end
        if (commit && !i_flag_select_n) begin
            if (!i_host_data[0] && own[f] == 2'h0) begin
                own[f] <= 2'h1;
            end else if (!i_host_data[0] && own[f] == 2'h2) begin
                our_wait[f] <= 1'b1;
            end else if (i_host_data[0] && own[f] == 2'h1) begin
                own[f] <= 2'h0;
            end
        end
        // Peer grant is applied last, so only one side ends up owner
        if (i_peer_req && own[1] == 2'h0) begin
            own[1] <= 2'h2;
        end
        if (i_peer_rel && own[1] == 2'h2) begin
            own[1] <= {1'b0, our_wait[1]};
            our_wait[1] <= 1'b0;
        end
    end
endmodule

// ===== dpa_pkg.sv
// Constants and types for the dual-port RAM port controller
package dpa_pkg;
    // Clock period in picoseconds (250 MHz)
    localparam int CLK_PS = 4000;

    // Device timing figures in nanoseconds
    localparam int WRITE_PULSE_WIDTH_NS = 16;
    localparam int DATA_SETUP_NS = 12;
    localparam int STROBE_TO_TRISTATE_NS = 12;
    localparam int ACCESS_TIME_NS = 20;
    localparam int FLAG_ACCESS_TIME_NS = 20;
    localparam int FLAG_UPDATE_PULSE_NS = 10;
    localparam int FLAG_WRITE_TO_READ_NS = 5;
    localparam int SLAVE_STROBE_HOLD_NS = 15;
    localparam int COLLISION_RELEASE_TO_DATA_NS = 20;
    localparam int SELECT_TO_WRITE_END_NS = 16;

    // Least times rounded up to whole cycles
    localparam int PWE_CYC =
        (WRITE_PULSE_WIDTH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int PWE_OE_CYC =
        ((STROBE_TO_TRISTATE_NS + DATA_SETUP_NS) * 1000 + CLK_PS - 1)
        / CLK_PS;
    localparam int ACC_CYC = (ACCESS_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FACC_CYC =
        (FLAG_ACCESS_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FUPD_CYC =
        (FLAG_UPDATE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FWTR_CYC =
        (FLAG_WRITE_TO_READ_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SHOLD_CYC =
        (SLAVE_STROBE_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int BDD_CYC =
        (COLLISION_RELEASE_TO_DATA_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SCE_CYC =
        (SELECT_TO_WRITE_END_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // Cycles between accesses after a plain access
    localparam int GAP_CYC = 1;
    // Cycles between accesses after a flag write
    localparam int FGAP_CYC = (FUPD_CYC > FWTR_CYC) ? FUPD_CYC : FWTR_CYC;

    // Width of the timing down-counter
    localparam int CNT_W = 4;
    // Reset value of the shared data and address registers
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // User commands
    typedef enum logic [1:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_FLAG_READ,
        CMD_FLAG_WRITE
    } dpa_cmd_t;
endpackage

// ===== dpa_port_ctrl.sv
// Host-side controller driving one port of an async dual-port RAM
//
// Overview of operation
// - Array select low for RAM, flag select low for flags, held through write.
// - Strobe stays high whenever the port address changes.
// - Strobe write pulse stretched when output drive is low during writes.
// - Slave port keeps strobe high 15 ns after collision release.
// - Flag select returns high at least 10 ns between flag write and read.
// - At least 5 ns from flag write end to checking read.
// - Each flag read uses a fresh flag select cycle.
// - Reads use strobe high, select low, output drive low.
// - Flag request writes zero on data bit zero with array deselected.
// - Array select held high during data retention, except for an access already under way.
`timescale 1ns/100ps
module dpa_port_ctrl #(
    parameter int P_ADDR_W = 15,
    parameter int P_DATA_W = 9,
    parameter bit P_ROLE_MASTER = 1'b1,
    parameter bit P_OE_LOW_WRITES = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire logic [1:0] i_cmd,
    input wire logic [P_ADDR_W-1:0] i_addr,
    input wire logic [P_DATA_W-1:0] i_wdata,
    input wire logic i_retention,
    input wire logic [P_DATA_W-1:0] i_data_in,
    input wire logic i_collision_n,
    output logic o_ready,
    output logic o_done,
    output logic [P_DATA_W-1:0] o_rdata,
    output logic o_collided,
    output logic [P_ADDR_W-1:0] o_addr,
    output logic o_array_sel_n,
    output logic o_flag_select_n,
    output logic o_rw_n,
    output logic o_out_drive_n,
    output logic [P_DATA_W-1:0] o_data_out,
    output logic o_data_oe,
    output logic o_role_master
);
    localparam int CW = dpa_pkg::CNT_W;

    // Refuse widths the device family cannot have
    if (P_ADDR_W < 12 || P_ADDR_W > 17) begin : g_chk_addr
        $error("dpa_port_ctrl: address width out of range");
    end
    if (P_DATA_W < 8 || P_DATA_W > 9) begin : g_chk_data
        $error("dpa_port_ctrl: data width must be 8 or 9");
    end
    if (dpa_pkg::PWE_OE_CYC >= (1 << CW)) begin : g_chk_cnt
        $error("dpa_port_ctrl: counter too narrow");
    end
    // Waits must fit the counter and last at least one cycle; GAP_CYC is checked only for the floor, FGAP_CYC and SCE_CYC only for the ceiling
    if (dpa_pkg::ACC_CYC < 1 || dpa_pkg::ACC_CYC > (1 << CW) ||
            dpa_pkg::FACC_CYC < 1 || dpa_pkg::FACC_CYC > (1 << CW) ||
            dpa_pkg::BDD_CYC < 1 || dpa_pkg::BDD_CYC > (1 << CW) ||
            dpa_pkg::SHOLD_CYC < 1 || dpa_pkg::SHOLD_CYC > (1 << CW) ||
            dpa_pkg::GAP_CYC < 1 || dpa_pkg::FGAP_CYC > (1 << CW) ||
            dpa_pkg::SCE_CYC > (1 << CW)) begin : g_chk_waits
        $error("dpa_port_ctrl: wait count does not fit the counter");
    end

    // Write pulse length in cycles, with or without output drive low
    localparam int PULSE_INT = (P_OE_LOW_WRITES &&
        dpa_pkg::PWE_OE_CYC > dpa_pkg::PWE_CYC) ?
        dpa_pkg::PWE_OE_CYC : dpa_pkg::PWE_CYC;
    localparam int SEL_PULSE_INT = (dpa_pkg::SCE_CYC > PULSE_INT) ?
        dpa_pkg::SCE_CYC : PULSE_INT;
    localparam logic [CW-1:0] PULSE_LD = CW'(SEL_PULSE_INT - 1);
    localparam logic [CW-1:0] ACC_LD = CW'(dpa_pkg::ACC_CYC - 1);
    localparam logic [CW-1:0] FACC_LD = CW'(dpa_pkg::FACC_CYC - 1);
    localparam logic [CW-1:0] BDD_LD = CW'(dpa_pkg::BDD_CYC - 1);
    localparam logic [CW-1:0] SHOLD_LD = CW'(dpa_pkg::SHOLD_CYC - 1);
    localparam logic [CW-1:0] GAP_LD = CW'(dpa_pkg::GAP_CYC - 1);
    localparam logic [CW-1:0] FGAP_LD = CW'(dpa_pkg::FGAP_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_BUSY_WAIT,
        ST_SLAVE_HOLD,
        ST_PULSE,
        ST_READ,
        ST_RELEASE,
        ST_RECOVER
    } dpa_state_t;

    dpa_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [1:0] cmd_reg, cmd_next;
    logic [P_ADDR_W-1:0] addr_reg, addr_next;
    logic [P_DATA_W-1:0] wdata_reg, wdata_next;
    logic [P_DATA_W-1:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;
    logic coll_reg, coll_next;
    logic asel_reg, asel_next;
    logic fsel_reg, fsel_next;
    logic rw_reg, rw_next;
    logic oe_reg, oe_next;
    logic doe_reg, doe_next;
    logic is_flag, is_write;

    assign is_flag = (cmd_reg == dpa_pkg::CMD_FLAG_READ) ||
        (cmd_reg == dpa_pkg::CMD_FLAG_WRITE);
    assign is_write = (cmd_reg == dpa_pkg::CMD_WRITE) ||
        (cmd_reg == dpa_pkg::CMD_FLAG_WRITE);

    // Access sequencer: next values
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        ready_next = ready_reg;
        done_next = 1'b0;
        coll_next = coll_reg;
        asel_next = asel_reg;
        fsel_next = fsel_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        doe_next = doe_reg;
        unique case (state_reg)
            ST_IDLE: begin
                // Selects high here keep the array idle in retention
                asel_next = 1'b1;
                fsel_next = 1'b1;
                if (i_req && ready_reg && !i_retention) begin
                    // Address moves only while the strobe is high
                    addr_next = i_addr;
                    cmd_next = i_cmd;
                    wdata_next = i_wdata;
                    coll_next = 1'b0;
                    ready_next = 1'b0;
                    state_next = ST_SETUP;
                end else begin
                    ready_next = !i_retention;
                end
            end
            ST_SETUP: begin
                // Exactly one select low, chosen by the command
                asel_next = is_flag;
                fsel_next = !is_flag;
                if (is_write) begin
                    oe_next = !P_OE_LOW_WRITES;
                    if (!i_collision_n) begin
                        coll_next = 1'b1;
                        state_next = ST_BUSY_WAIT;
                    end else begin
                        rw_next = 1'b0;
                        doe_next = 1'b1;
                        cnt_next = PULSE_LD;
                        state_next = ST_PULSE;
                    end
                end else begin
                    // Read: strobe high, output drive low
                    oe_next = 1'b0;
                    cnt_next = is_flag ? FACC_LD : ACC_LD;
                    state_next = ST_READ;
                end
            end
            ST_BUSY_WAIT: begin
                // Strobe stays high until the collision input clears
                if (i_collision_n) begin
                    cnt_next = SHOLD_LD;
                    state_next = ST_SLAVE_HOLD;
                end
            end
            ST_SLAVE_HOLD: begin
                if (!i_collision_n) begin
                    coll_next = 1'b1;
                    state_next = ST_BUSY_WAIT;
                end else if (cnt_reg == '0) begin
                    rw_next = 1'b0;
                    doe_next = 1'b1;
                    cnt_next = PULSE_LD;
                    state_next = ST_PULSE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_PULSE: begin
                // Selects stay low for the whole pulse; strobe ends it
                if (cnt_reg == '0) begin
                    rw_next = 1'b1;
                    state_next = ST_RELEASE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_READ: begin
                if (!i_collision_n) begin
                    // Data settles only after the collision clears
                    coll_next = 1'b1;
                    cnt_next = BDD_LD;
                end else if (cnt_reg == '0) begin
                    rdata_next = i_data_in;
                    oe_next = 1'b1;
                    state_next = ST_RELEASE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_RELEASE: begin
                // Every access ends with both selects high
                asel_next = 1'b1;
                fsel_next = 1'b1;
                doe_next = 1'b0;
                oe_next = 1'b1;
                done_next = 1'b1;
                cnt_next = (cmd_reg == dpa_pkg::CMD_FLAG_WRITE) ?
                    FGAP_LD : GAP_LD;
                state_next = ST_RECOVER;
            end
            ST_RECOVER: begin
                if (cnt_reg == '0) begin
                    ready_next = !i_retention;
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
    end

    // Access sequencer: registers
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            cmd_reg <= dpa_pkg::CMD_READ;
            addr_reg <= P_ADDR_W'(dpa_pkg::ZERO_RST);
            wdata_reg <= P_DATA_W'(dpa_pkg::ZERO_RST);
            rdata_reg <= P_DATA_W'(dpa_pkg::ZERO_RST);
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            coll_reg <= 1'b0;
            asel_reg <= 1'b1;
            fsel_reg <= 1'b1;
            rw_reg <= 1'b1;
            oe_reg <= 1'b1;
            doe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            coll_reg <= coll_next;
            asel_reg <= asel_next;
            fsel_reg <= fsel_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            doe_reg <= doe_next;
        end
    end

    // Role strap register
    logic role_reg;
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            role_reg <= 1'b0;
        end else begin
            role_reg <= P_ROLE_MASTER;
        end
    end

    // Outputs straight from flip-flops
    assign o_ready = ready_reg;
    assign o_done = done_reg;
    assign o_rdata = rdata_reg;
    assign o_collided = coll_reg;
    assign o_addr = addr_reg;
    assign o_array_sel_n = asel_reg;
    assign o_flag_select_n = fsel_reg;
    assign o_rw_n = rw_reg;
    assign o_out_drive_n = oe_reg;
    assign o_data_out = wdata_reg;
    assign o_data_oe = doe_reg;
    assign o_role_master = role_reg;
endmodule

// ===== tb_top.sv
// Self-checking bench for the port controller and device model
`timescale 1ns/100ps
module tb_top;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic req = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic [14:0] addr = 15'h0000;
    logic [8:0] wd = 9'h000;
    logic ret = 1'b0;
    logic coll_n = 1'b1;
    logic p_req = 1'b0;
    logic p_rel = 1'b0;
    logic [8:0] bus, dout, rdata;
    logic ready, done, colld, asel_n, fsel_n, rw_n, odrv_n, doe, role;
    logic [14:0] a_out;
    int err_count = 0;
    int n_checks = 0;
    int lat;
    // Rows: command, address, write data, expected read data
    logic [34:0] rows [8] = '{{2'h2, 15'h0002, 9'h000, 9'h1ff},
        {2'h1, 15'h0005, 9'h1a5, 9'h000}, {2'h1, 15'h0007, 9'h0ff, 9'h000},
        {2'h0, 15'h0005, 9'h000, 9'h1a5}, {2'h0, 15'h0007, 9'h000, 9'h0ff},
        {2'h3, 15'h0003, 9'h000, 9'h000}, {2'h2, 15'h0003, 9'h000, 9'h000},
        {2'h3, 15'h0003, 9'h001, 9'h000}};
    dpa_port_ctrl dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(req),
        .i_cmd(cmd), .i_addr(addr), .i_wdata(wd), .i_retention(ret),
        .i_data_in(bus), .i_collision_n(coll_n), .o_ready(ready),
        .o_done(done), .o_rdata(rdata), .o_collided(colld), .o_addr(a_out),
        .o_array_sel_n(asel_n), .o_flag_select_n(fsel_n), .o_rw_n(rw_n),
        .o_out_drive_n(odrv_n), .o_data_out(dout), .o_data_oe(doe),
        .o_role_master(role));
    dpa_dev_model u_dev (.i_clock(i_clock), .i_addr(a_out),
        .i_array_sel_n(asel_n), .i_flag_select_n(fsel_n), .i_rw_n(rw_n),
        .i_out_drive_n(odrv_n), .i_host_data(dout), .i_host_oe(doe),
        .i_peer_req(p_req), .i_peer_rel(p_rel), .o_bus(bus));
    // Clock
    always #2 i_clock = ~i_clock;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One access; lat counts cycles from take to done
    task automatic acc(input logic [1:0] c, input logic [14:0] a,
            input logic [8:0] d);
        int k;
        k = 0;
        do begin
            @(negedge i_clock);
            k++;
        end while (ready !== 1'b1 && k < 60);
        if (k >= 60) err_count++;
        @(posedge i_clock);
        req <= 1'b1;
        cmd <= c;
        addr <= a;
        wd <= d;
        @(posedge i_clock);
        req <= 1'b0;
        lat = 0;
        do begin
            @(negedge i_clock);
            lat++;
        end while (done !== 1'b1 && lat < 60);
        if (lat >= 60) err_count++;
    endtask
    // Access with the collision line pulled low part way
    task automatic coll_acc(input logic [1:0] c, input logic [14:0] a,
            input logic [8:0] d);
        fork
            acc(c, a, d);
            begin
                // Low in time for the select edge of a write to see it
                repeat (3) @(posedge i_clock);
                coll_n <= 1'b0;
                repeat (6) @(posedge i_clock);
                coll_n <= 1'b1;
            end
        join
        cmp({15'h0000, colld}, 16'h0001);
        cmp({15'h0000, lat > 8}, 16'h0001);
    endtask
    task automatic pulse_peer(input logic rel);
        @(posedge i_clock);
        p_req <= !rel;
        p_rel <= rel;
        @(posedge i_clock);
        p_req <= 1'b0;
        p_rel <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (19) @(posedge i_clock);
        @(negedge i_clock);
        cmp({11'h000, ready, role, asel_n, fsel_n, rw_n}, 16'h0007);
        @(posedge i_clock);
        i_nrst <= 1'b1;
        foreach (rows[i]) begin
            acc(rows[i][34:33], rows[i][32:18], rows[i][17:9]);
            cmp(16'(lat), rows[i][33] ? 16'h0007 : 16'h0008);
            if (!rows[i][33]) begin
                cmp({7'h00, rdata}, {7'h00, rows[i][8:0]});
            end
        end
        cmp({15'h0000, role}, 16'h0001);
        // Peer holds flag 1; ours waits, then is handed over
        pulse_peer(1'b0);
        acc(2'h3, 15'h0001, 9'h000);
        acc(2'h2, 15'h0001, 9'h000);
        cmp({7'h00, rdata}, 16'h01ff);
        pulse_peer(1'b1);
        acc(2'h2, 15'h0001, 9'h000);
        cmp({7'h00, rdata}, 16'h0000);
        // Collision on a read and on a write
        coll_acc(2'h0, 15'h0005, 9'h000);
        cmp({7'h00, rdata}, 16'h01a5);
        coll_acc(2'h1, 15'h0009, 9'h0c3);
        // Retention refuses requests and keeps the array deselected
        @(posedge i_clock);
        ret <= 1'b1;
        req <= 1'b1;
        repeat (10) @(negedge i_clock);
        cmp({14'h0000, ready, asel_n}, 16'h0001);
        @(posedge i_clock);
        ret <= 1'b0;
        req <= 1'b0;
        acc(2'h0, 15'h0009, 9'h000);
        cmp({7'h00, rdata}, 16'h00c3);
        report_and_stop();
    end
    // Watchdog
    initial begin
        #(4 * 5000);
        err_count++;
        report_and_stop();
    end
endmodule
